// ==== logic/memory_interface_config_loader.sv ====
// start-up configuration loader for the external memory interface
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module memory_interface_config_loader
	import loader_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        device_reset,
	input  wire logic        diagnostic_hold,
	input  wire logic        input_reference_clock,
	input  wire logic        config_select_input,
	input  wire logic        external_bus_request,
	input  wire logic [31:0] multiplexed_addr_data_bus_in,
	output logic      [31:0] multiplexed_addr_data_bus_out,
	output logic             multiplexed_addr_data_bus_oe,
	output logic             read_strobe_n,
	output logic      [3:0]  byte_write_strobes_n,
	output logic      [4:0]  general_strobes_n,
	output logic             refresh_active,
	output logic             config_done,
	output logic             bootstrap_start,
	output logic             bus_request_granted,
	output logic      [35:0] cfg_word
);
	import loader_pkg::*;

	state_t      state;
	state_t      next_state;
	logic        ref_q;
	logic [9:0]  ref_cnt;
	logic [5:0]  read_idx;
	logic [2:0]  refr_idx;
	logic [3:0]  scan_slot;
	logic [12:0] hit_mask;
	logic [35:0] read_word;
	logic        cyc_start;
	logic        next_cyc_start;
	logic        ctrl_busreq_en;
	logic [3:0]  preset_idx;
	logic [31:0] next_bus;
	logic        next_oe;
	logic [4:0]  next_gs_n;
	logic [31:0] rd_mux;

	wire         cyc_busy;
	wire  [2:0]  phase;
	wire  [5:0]  since_t2;
	wire         sample_p;
	wire         done_p;

	// the reads always run on the slowest timing, whatever gets adopted
	wire  [35:0] cfg_act = (state == ST_READ) ? CFG_DEFAULT : cfg_word;
	wire         ref_en  = cfg_word[F_REN_BIT];
	wire  [9:0]  interval = 10'(({8'h0, cfg_word[F_RINT_LSB +: 2]} + 10'h1)
		* 10'(REF_UNIT));

	// reference clock is sampled as a plain synchronous input
	wire         ref_edge = input_reference_clock & ~ref_q;

	// length of the current timed wait in reference periods
	wire  [9:0]  wait_len =
		(state == ST_DELAY)   ? 10'(START_DELAY_REF) :
		(state == ST_SCAN)    ? 10'(SCAN_LEN_REF) :
		(state == ST_REFWAIT) ? 10'(interval << 3) :
		interval;
	wire         wait_done = ref_edge && (ref_cnt == wait_len - 10'h1);

	// exactly one line must have followed the select input
	wire         preset_ok = (hit_mask != 13'h0)
		&& ((hit_mask & (hit_mask - 13'h1)) == 13'h0);
	wire  [4:0]  scan_line = (scan_slot == 4'(PRESET_COUNT - 1))
		? 5'(PRESET_TOP_LINE) : {1'b0, scan_slot};
	// the pins lag the slot counter by one clock, so mark the slot shown
	wire  [3:0]  shown_slot = (scan_slot == 4'h0)
		? 4'(PRESET_COUNT - 1) : scan_slot - 4'h1;

	// register decode for the bus slave
	wire         wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire         sel_ctrl  = (wb_adr_i == ADDR_CTRL);
	wire         sel_stat  = (wb_adr_i == ADDR_STATUS);
	wire         sel_cfglo = (wb_adr_i == ADDR_CFG_LO);
	wire         sel_cfghi = (wb_adr_i == ADDR_CFG_HI);

	// strobe window of a memory cycle: T2 up to the start of T6
	wire         win = cyc_busy && (phase >= 3'h2) && (phase <= 3'h5)
		&& !device_reset && (state == ST_READ || state == ST_REFRESH);
	wire         addr_phase = cyc_busy && (phase <= 3'h2);

	mem_cycle_seq #(
		.TM_CYC      (TM_CYCLES)
	) u_cycle (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.start       (cyc_start),
		.phase_extra (cfg_act[F_PHASE_LSB +: 12]),
		.busy        (cyc_busy),
		.phase       (phase),
		.since_t2    (since_t2),
		.sample_p    (sample_p),
		.done_p      (done_p)
	);

	// lowest line that followed the select input during the scan
	always_comb begin
		preset_idx = 4'h0;
		for (int i = PRESET_COUNT - 1; i >= 0; i--) begin
			if (hit_mask[i])
				preset_idx = 4'(i);
		end
	end

	// sequencer; a raised device reset always wins
	always_comb begin
		next_state = state;
		case (state)
			ST_HELD:
				if (!device_reset)
					next_state = diagnostic_hold ? ST_DIAG : ST_DELAY;
			ST_DIAG:
				next_state = ST_DIAG;
			ST_DELAY:
				if (wait_done)
					next_state = ST_SCAN;
			ST_SCAN:
				if (wait_done)
					next_state = ST_READ;
			ST_READ:
				if (done_p && read_idx == 6'(CFG_READS - 1))
					next_state = ST_SETTLE;
			ST_SETTLE:
				if (wait_done)
					next_state = ref_en ? ST_REFRESH : ST_REFWAIT;
			ST_REFRESH:
				if (done_p && refr_idx == 3'(REFRESH_COUNT - 1))
					next_state = ST_BOOT;
			ST_REFWAIT:
				if (wait_done)
					next_state = ST_BOOT;
			ST_BOOT:
				next_state = ST_BOOT;
			default:
				next_state = ST_HELD;
		endcase
		if (device_reset)
			next_state = ST_HELD;
	end

	// launch each configuration read and each refresh cycle
	assign next_cyc_start = !device_reset && (
		(state == ST_SCAN && wait_done) ||
		(state == ST_READ && done_p && read_idx != 6'(CFG_READS - 1)) ||
		(state == ST_SETTLE && wait_done && ref_en) ||
		(state == ST_REFRESH && done_p
			&& refr_idx != 3'(REFRESH_COUNT - 1)));

	// bus drive: walking one in the scan, addresses in T1 and T2
	always_comb begin
		next_bus = 32'h0;
		next_oe  = 1'b0;
		if (state == ST_SCAN) begin
			next_bus = 32'h1 << scan_line;
			next_oe  = 1'b1;
		end else if (state == ST_READ && addr_phase) begin
			next_bus = CFG_READ_BASE + {24'h0, read_idx, 2'b00};
			next_oe  = 1'b1;
		end else if (state == ST_REFRESH && addr_phase) begin
			next_bus = REFRESH_IDLE | {20'h0, 3'h0, refr_idx, 6'h0};
			next_oe  = 1'b1;
		end
	end

	// general strobes; s1 is a width, s2 to s4 are leading-edge delays
	always_comb begin
		next_gs_n    = 5'h1F;
		next_gs_n[0] = !win;
		next_gs_n[1] = !(win && since_t2 < 6'(cfg_act[F_S1_LSB +: 5]));
		next_gs_n[2] = !(win && since_t2 >= 6'(cfg_act[F_S2_LSB +: 5]));
		next_gs_n[3] = !(win && since_t2 >= 6'(cfg_act[F_S3_LSB +: 5]));
		next_gs_n[4] = !(win && since_t2 >= 6'(cfg_act[F_S4_LSB +: 5]));
		if (state == ST_SCAN)
			next_gs_n = 5'h1F;
	end

	// read data multiplexer, unmapped offsets read as zero
	always_comb begin
		rd_mux = 32'h0;
		if (sel_ctrl)
			rd_mux = {31'h0, ctrl_busreq_en};
		else if (sel_stat)
			rd_mux = {18'h0, preset_ok, preset_idx, refr_idx, bootstrap_start,
				config_done, state};
		else if (sel_cfglo)
			rd_mux = cfg_word[31:0];
		else if (sel_cfghi)
			rd_mux = {28'h0, cfg_word[35:32]};
	end

	// state register and reference clock edge history
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= ST_HELD;
			ref_q     <= 1'b0;
			cyc_start <= 1'b0;
		end else begin
			state     <= next_state;
			ref_q     <= input_reference_clock;
			cyc_start <= next_cyc_start;
		end
	end

	// reference period counter restarts with every state change
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			ref_cnt <= 10'h0;
		else if (state != next_state)
			ref_cnt <= 10'h0;
		else if (ref_edge)
			ref_cnt <= ref_cnt + 10'h1;
	end

	// scan slot rotates every clock; a high select marks that line
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			scan_slot <= 4'h0;
			hit_mask  <= 13'h0;
		end else if (state == ST_HELD) begin
			scan_slot <= 4'h0;
			hit_mask  <= 13'h0;
		end else if (state == ST_SCAN) begin
			scan_slot <= (scan_slot == 4'(PRESET_COUNT - 1))
				? 4'h0 : scan_slot + 4'h1;
			if (multiplexed_addr_data_bus_oe && config_select_input)
				hit_mask[shown_slot] <= 1'b1;
		end
	end

	// serial word capture; each bit is taken complemented at end of T5
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			read_word <= CFG_DEFAULT;
		else if (state == ST_READ && sample_p)
			read_word[read_idx] <= ~config_select_input;
	end

	// read and refresh cycle counters
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			read_idx <= 6'h0;
			refr_idx <= 3'h0;
		end else if (state == ST_HELD) begin
			read_idx <= 6'h0;
			refr_idx <= 3'h0;
		end else if (done_p) begin
			if (state == ST_READ)
				read_idx <= read_idx + 6'h1;
			if (state == ST_REFRESH)
				refr_idx <= refr_idx + 3'h1;
		end
	end

	// configuration store: loaded once, held until the next reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			cfg_word <= CFG_DEFAULT;
		else if (state == ST_HELD || device_reset)
			cfg_word <= CFG_DEFAULT;
		else if (state == ST_READ && next_state == ST_SETTLE)
			cfg_word <= preset_ok ? preset_word(preset_idx)
				: read_word;
	end

	// pin outputs; no write cycles run here so byte strobes stay high
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			multiplexed_addr_data_bus_out <= 32'h0;
			multiplexed_addr_data_bus_oe  <= 1'b0;
			general_strobes_n             <= 5'h1F;
			read_strobe_n                 <= 1'b1;
			byte_write_strobes_n          <= 4'hF;
			refresh_active                <= 1'b0;
		end else begin
			multiplexed_addr_data_bus_out <= next_bus;
			multiplexed_addr_data_bus_oe  <= next_oe;
			general_strobes_n             <= next_gs_n;
			read_strobe_n <= !(state == ST_READ && cyc_busy
				&& (phase == 3'h4 || phase == 3'h5)
				&& !device_reset);
			byte_write_strobes_n          <= 4'hF;
			refresh_active <= (state == ST_REFRESH) && cyc_busy;
		end
	end

	// completion flags; the write style travels out in cfg_word
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_done         <= 1'b0;
			bootstrap_start     <= 1'b0;
			bus_request_granted <= 1'b0;
		end else begin
			config_done     <= (next_state == ST_BOOT);
			bootstrap_start <= (next_state == ST_BOOT)
				&& (state != ST_BOOT);
			// a request before completion is simply not seen
			bus_request_granted <= (state == ST_BOOT) && ctrl_busreq_en
				&& external_bus_request;
		end
	end

	// bus slave: one wait state, ack dropped in the following cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0;
			ctrl_busreq_en <= CTRL_RESET;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
			if (wb_req && wb_we_i && sel_ctrl && wb_sel_i[0])
				ctrl_busreq_en <= wb_dat_i[0];
		end
	end

endmodule // memory_interface_config_loader

// ==== inc/loader_pkg.sv ====
// constants, field layout and preset table for the memory config loader
package loader_pkg;

	// clock and half-cycle period
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROC_CYCLE_NS = 40;
	localparam int TM_NS         = PROC_CYCLE_NS / 2;
	localparam int TM_CYCLES     = (TM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// sequence lengths, in reference clock periods or cycles
	localparam int START_DELAY_REF = 144;
	localparam int SCAN_LEN_REF    = 144;
	localparam int CFG_READS       = 36;
	localparam int REFRESH_COUNT   = 8;
	localparam int REF_UNIT        = 18;
	localparam int PRESET_COUNT    = 13;
	localparam int PRESET_TOP_LINE = 31;

	// configuration word layout, bit i is configuration read i
	localparam int          CFG_W        = 36;
	localparam int          F_PHASE_LSB  = 0;
	localparam int          F_S1_LSB     = 12;
	localparam int          F_S2_LSB     = 17;
	localparam int          F_S3_LSB     = 22;
	localparam int          F_S4_LSB     = 27;
	localparam int          F_RINT_LSB   = 32;
	localparam int          F_REN_BIT    = 34;
	localparam int          F_LATE_BIT   = 35;
	localparam logic [35:0] CFG_DEFAULT  = 36'hF_FFFF_FFFF;
	localparam logic [1:0]  RINT_72      = 2'h3;

	// bus addresses driven during configuration
	localparam logic [31:0] CFG_READ_BASE  = 32'h7FFF_FF6C;
	localparam logic [31:0] REFRESH_IDLE   = 32'h7FFF_F003;

	// register map
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_CFG_LO    = 8'h08;
	localparam logic [7:0]  ADDR_CFG_HI    = 8'h0C;
	localparam logic        CTRL_RESET     = 1'h0;

	typedef enum logic [3:0] {
		ST_HELD    = 4'b0000,
		ST_DIAG    = 4'b0001,
		ST_DELAY   = 4'b0010,
		ST_SCAN    = 4'b0011,
		ST_READ    = 4'b0100,
		ST_SETTLE  = 4'b0101,
		ST_REFRESH = 4'b0110,
		ST_REFWAIT = 4'b0111,
		ST_BOOT    = 4'b1000
	} state_t;

	// packs one preset row; lengths are stored as extra periods
	function automatic logic [35:0] mk(input int t1, t2, t3, t4, t5, t6,
		input int s1, s2, s3, s4, input logic late, input logic ren);
		mk = {late, ren, RINT_72, 5'(s4), 5'(s3), 5'(s2), 5'(s1),
			2'(t6 - 1), 2'(t5 - 1), 2'(t4 - 1), 2'(t3 - 1),
			2'(t2 - 1), 2'(t1 - 1)};
	endfunction

	// preset rows; slot 12 stands for the top bus line
	function automatic logic [35:0] preset_word(input logic [3:0] i);
		case (i)
			4'h0: preset_word = mk(1, 1, 1, 1, 1, 1, 30, 1, 3, 5, 1'b1, 1'b1);
			4'h1: preset_word = mk(1, 2, 1, 1, 1, 2, 30, 1, 2, 7, 1'b1, 1'b1);
			4'h2: preset_word = mk(1, 2, 1, 1, 2, 3, 30, 1, 2, 7, 1'b1, 1'b1);
			4'h3: preset_word = mk(2, 3, 1, 1, 2, 3, 30, 1, 3, 8, 1'b1, 1'b1);
			4'h4: preset_word = mk(1, 1, 1, 1, 1, 1, 3, 1, 2, 3, 1'b0, 1'b1);
			4'h5: preset_word = mk(1, 1, 2, 1, 2, 1, 5, 1, 2, 3, 1'b0, 1'b1);
			4'h6: preset_word = mk(2, 1, 2, 1, 3, 1, 6, 1, 2, 3, 1'b0, 1'b1);
			4'h7: preset_word = mk(2, 2, 2, 1, 3, 2, 7, 1, 3, 4, 1'b0, 1'b1);
			4'h8: preset_word = mk(1, 1, 1, 1, 1, 1, 30, 1, 2, 3, 1'b0, 1'b0);
			4'h9: preset_word = mk(1, 1, 2, 1, 2, 1, 30, 2, 5, 9, 1'b0, 1'b0);
			4'hA: preset_word = mk(2, 2, 2, 2, 4, 2, 30, 2, 3, 8, 1'b1, 1'b1);
			4'hB: preset_word = mk(3, 3, 3, 3, 3, 3, 30, 2, 4, 13, 1'b1, 1'b1);
			default: preset_word = CFG_DEFAULT;
		endcase
	endfunction

endpackage

// ==== logic/mem_cycle_seq.sv ====
// six-phase external memory cycle timer counted in half-cycle periods
`timescale 1ns/1ps
module mem_cycle_seq #(
	parameter int TM_CYC = 1
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [11:0] phase_extra,
	output logic             busy,
	output logic [2:0]       phase,
	output logic [5:0]       since_t2,
	output logic             sample_p,
	output logic             done_p
);
	logic [7:0] div;
	logic [1:0] cnt;
	wire        tick;
	wire  [2:0] pidx;
	wire  [1:0] cur_extra;
	wire        last;

	// one tick per half-cycle period; the phase ends once its extra count ran
	assign tick      = (div == 8'(TM_CYC - 1));
	assign pidx      = busy ? phase - 3'h1 : 3'h0; // idle keeps the select in range
	assign cur_extra = phase_extra[{pidx, 1'b0} +: 2];
	assign last      = tick && (cnt == cur_extra);
	assign busy      = (phase != 3'h0);
	assign sample_p  = last && (phase == 3'h5); // data latched at end of T5
	assign done_p    = last && (phase == 3'h6);

	// phase and period counters; start restarts the cycle at T1
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div      <= 8'h0;
			cnt      <= 2'h0;
			phase    <= 3'h0;
			since_t2 <= 6'h0;
		end else if (start) begin
			div      <= 8'h0;
			cnt      <= 2'h0;
			phase    <= 3'h1;
			since_t2 <= 6'h0;
		end else if (busy) begin
			div <= tick ? 8'h0 : div + 8'h1;
			if (tick) begin
				cnt      <= last ? 2'h0 : cnt + 2'h1;
				since_t2 <= (phase >= 3'h2) ? since_t2 + 6'h1 : 6'h0;
			end
			if (last)
				phase <= (phase == 3'h6) ? 3'h0 : phase + 3'h1;
		end
	end

endmodule // mem_cycle_seq

// ==== sim/config_loader_monitor.sv ====
// port-level checker for the memory interface config loader
`timescale 1ns/1ps
module config_loader_monitor (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        device_reset,
	input wire logic        input_reference_clock,
	input wire logic        multiplexed_addr_data_bus_oe,
	input wire logic        read_strobe_n,
	input wire logic [3:0]  byte_write_strobes_n,
	input wire logic [4:0]  general_strobes_n,
	input wire logic        refresh_active,
	input wire logic        config_done,
	input wire logic        bootstrap_start,
	input wire logic        bus_request_granted,
	input wire logic [35:0] cfg_word
);
	default clocking mon_cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic       ref_q;
	logic [9:0] ref_cnt;

	// counts reference edges since release; saturates so a long run stays quiet
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_q <= 1'b0;
			ref_cnt <= 10'h000;
		end else begin
			ref_q <= input_reference_clock;
			if (device_reset)
				ref_cnt <= 10'h000;
			else if (input_reference_clock && !ref_q && ref_cnt != 10'h3FF)
				ref_cnt <= ref_cnt + 10'h001;
		end
	end

	property p_held;
		device_reset && $past(device_reset) |->
			read_strobe_n && general_strobes_n == 5'h1F && !config_done;
	endproperty
	property p_store;
		device_reset && $past(device_reset) |-> cfg_word == 36'hF_FFFF_FFFF;
	endproperty
	property p_wr_idle;
		byte_write_strobes_n == 4'hF;
	endproperty
	property p_scan;
		!device_reset && ref_cnt < 10'h120 |->
			read_strobe_n && general_strobes_n == 5'h1F && !refresh_active;
	endproperty
	property p_grant;
		!config_done && !$past(config_done) |-> !bus_request_granted;
	endproperty
	property p_boot;
		bootstrap_start |=> !bootstrap_start && config_done;
	endproperty
	property p_boot_done;
		$rose(bootstrap_start) |-> ##[0:1] config_done;
	endproperty
	property p_cfg_hold;
		config_done && $past(config_done) |-> $stable(cfg_word);
	endproperty
	property p_ref_rd;
		refresh_active |-> read_strobe_n;
	endproperty
	property p_rd_oe;
		!read_strobe_n |-> !multiplexed_addr_data_bus_oe;
	endproperty
	property p_done_stay;
		config_done && !device_reset |=> config_done;
	endproperty

	a_held:      assert property (p_held)
		else $error("strobes or done active while held");
	a_store:     assert property (p_store)
		else $error("store not all ones while held");
	a_wr_idle:   assert property (p_wr_idle)
		else $error("byte write strobe active");
	a_scan:      assert property (p_scan)
		else $error("strobe active during delay or scan");
	a_grant:     assert property (p_grant)
		else $error("bus request granted before configuration");
	a_boot:      assert property (p_boot)
		else $error("bootstrap pulse too long or done missing");
	a_boot_done: assert property (p_boot_done)
		else $error("bootstrap without done");
	a_cfg_hold:  assert property (p_cfg_hold)
		else $error("store changed after configuration");
	a_ref_rd:    assert property (p_ref_rd)
		else $error("read strobe during refresh");
	a_rd_oe:     assert property (p_rd_oe)
		else $error("bus driven during read data phase");
	a_done_stay: assert property (p_done_stay)
		else $error("done dropped without reset");

	c_boot:  cover property ($rose(bootstrap_start));
	c_ref:   cover property ($rose(refresh_active));
	c_read:  cover property ($fell(read_strobe_n));
	c_grant: cover property ($rose(bus_request_granted));
endmodule // config_loader_monitor

bind memory_interface_config_loader config_loader_monitor mon (
	.core_clk(core_clk), .reset_n(reset_n), .device_reset(device_reset),
	.input_reference_clock(input_reference_clock),
	.multiplexed_addr_data_bus_oe(multiplexed_addr_data_bus_oe),
	.read_strobe_n(read_strobe_n), .byte_write_strobes_n(byte_write_strobes_n),
	.general_strobes_n(general_strobes_n), .refresh_active(refresh_active),
	.config_done(config_done), .bootstrap_start(bootstrap_start),
	.bus_request_granted(bus_request_granted), .cfg_word(cfg_word));

// ==== sim/config_source.sv ====
// far-side model: preset strap wire or serial configuration logic
`timescale 1ns/1ps
module config_source (
	input  wire logic        core_clk,
	input  wire logic        serial_mode,
	input  wire logic [4:0]  preset_line,
	input  wire logic [35:0] serial_word,
	input  wire logic [31:0] bus_out,
	input  wire logic        bus_oe,
	input  wire logic        read_strobe_n,
	output logic             config_select_input
);
	logic [31:0] last_bus = 32'h0000_0000;
	logic [5:0]  bit_idx  = 6'h00;
	logic [31:0] offset;
	logic        line_level;

	// a released line shows the inverse of its last value, not a stale copy
	assign offset     = bus_out - 32'h7FFF_FF6C;
	assign line_level = bus_oe ? bus_out[preset_line] : ~last_bus[preset_line];

	// address phase of each read picks the bit that the read fetches
	always @(posedge core_clk) begin
		if (bus_oe)
			last_bus <= bus_out;
		if (bus_oe && offset < 32'h0000_0090)
			bit_idx <= offset[7:2];
	end

	// select wire straight to one line, or inverted serial data per read
	always_comb begin
		if (!serial_mode)
			config_select_input = line_level;
		else if (!read_strobe_n)
			config_select_input = ~serial_word[bit_idx];
		else
			config_select_input = 1'b0;
	end
endmodule // config_source

// ==== sim/memory_interface_config_loader_bench.sv ====
// self-checking bench for the memory interface config loader
`timescale 1ns/1ps
module memory_interface_config_loader_bench;
	import loader_pkg::*;
	typedef struct {
		logic [35:0] cfg;
		int          refs;
	} note_t;
	logic        core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, byte_write_strobes_n;
	logic [31:0] wb_dat_i, wb_dat_o, bus_out, addr_q;
	logic        device_reset, diagnostic_hold, input_reference_clock, sel;
	logic        external_bus_request, bus_oe, read_strobe_n, refresh_active;
	logic        config_done, bootstrap_start, bus_request_granted, serial_mode;
	logic [4:0]  general_strobes_n, preset_line;
	logic [35:0] cfg_word, serial_word, w;
	note_t       notes[$];
	note_t       nt;
	logic [31:0] rd_exp[$];
	int          fail_count, num_checks, n_reads, n_refs, ref_edges;
	logic        ref_q = 1'b0, rd_q1 = 1'b1, rf_q1 = 1'b0;

	memory_interface_config_loader DUT (.core_clk(core_clk), .reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .device_reset(device_reset),
		.diagnostic_hold(diagnostic_hold), .config_select_input(sel),
		.input_reference_clock(input_reference_clock),
		.external_bus_request(external_bus_request),
		.multiplexed_addr_data_bus_in(32'h0000_0000),
		.multiplexed_addr_data_bus_out(bus_out),
		.multiplexed_addr_data_bus_oe(bus_oe), .read_strobe_n(read_strobe_n),
		.byte_write_strobes_n(byte_write_strobes_n),
		.general_strobes_n(general_strobes_n), .refresh_active(refresh_active),
		.config_done(config_done), .bootstrap_start(bootstrap_start),
		.bus_request_granted(bus_request_granted), .cfg_word(cfg_word));

	config_source far_side (.core_clk(core_clk), .serial_mode(serial_mode),
		.preset_line(preset_line), .serial_word(serial_word),
		.bus_out(bus_out), .bus_oe(bus_oe), .read_strobe_n(read_strobe_n),
		.config_select_input(sel));

	// 50 MHz core clock; reference clock toggles each cycle
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) input_reference_clock <= ~input_reference_clock;

	task automatic chk(input string what, input logic [35:0] exp,
		input logic [35:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one classic cycle; holds the request until ack is sampled
	task automatic wb_cycle(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk("wb_ack_o", 36'h1, {35'h0, wb_ack_o});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp);
		rd_exp.push_back(exp);
		wb_cycle(1'b0, adr, 32'h0000_0000);
	endtask

	function automatic logic [35:0] pack(input logic [11:0] ext,
		input logic [4:0] s1, s2, s3, s4, input logic late, ren);
		return {late, ren, 2'h3, s4, s3, s2, s1, ext};
	endfunction

	// one full start-up; optional abort part way through the reads
	task automatic run_cfg(input logic ser, input logic [4:0] line,
		input logic [35:0] word, exp, input int refs, input logic abort);
		int n;
		device_reset <= 1'b1;
		serial_mode <= ser;
		preset_line <= line;
		serial_word <= word;
		repeat (4) @(posedge core_clk);
		if (abort) begin
			device_reset <= 1'b0;
			repeat (900) @(posedge core_clk);
			device_reset <= 1'b1;
			repeat (3) @(posedge core_clk);
			chk("abort_cfg", CFG_DEFAULT, cfg_word);
			chk("abort_done", 36'h0, {35'h0, config_done});
		end
		notes.push_back('{exp, refs});
		device_reset <= 1'b0;
		n = 0;
		while (bootstrap_start !== 1'b1 && n < 6000) begin
			@(posedge core_clk);
			n++;
		end
		chk("boot_seen", 36'h1, {35'h0, bootstrap_start});
		@(posedge core_clk);
		wb_read(ADDR_CFG_LO, exp[31:0]);
		wb_read(ADDR_CFG_HI, {28'h0, exp[35:32]});
		$display("test done: serial %0b line %0d", ser, line);
	endtask

	// watcher: counts reads and refreshes, settles each note on bootstrap
	always @(posedge core_clk) begin
		ref_q <= input_reference_clock;
		rd_q1 <= read_strobe_n;
		rf_q1 <= refresh_active;
		if (bus_oe === 1'b1)
			addr_q <= bus_out;
		if (device_reset) begin
			n_reads = 0;
			n_refs = 0;
			ref_edges = 0;
		end else begin
			if (input_reference_clock && !ref_q)
				ref_edges++;
			if (rd_q1 && read_strobe_n === 1'b0) begin
				if (n_reads == 0)
					chk("scan_end", 36'h1, ref_edges >= 288 && ref_edges <= 310);
				chk("read_addr", CFG_READ_BASE + 32'(4 * n_reads), addr_q);
				n_reads++;
			end
			if (refresh_active === 1'b1 && !rf_q1)
				n_refs++;
			if (bootstrap_start === 1'b1 && notes.size() > 0) begin
				nt = notes.pop_front();
				chk("cfg_word", nt.cfg, cfg_word);
				chk("refreshes", 36'(nt.refs), 36'(n_refs));
				chk("reads", 36'(CFG_READS), 36'(n_reads));
			end
		end
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_exp.size() > 0)
			chk("wb_dat_o", 36'(rd_exp.pop_front()), 36'(wb_dat_o));
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, serial_mode} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		{device_reset, diagnostic_hold, input_reference_clock} = 3'h4;
		external_bus_request = 1'b0;
		preset_line = 5'h00;
		serial_word = 36'h0_0000_0000;
		void'($urandom(32'hCE62D65A));
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		chk("reset_cfg", CFG_DEFAULT, cfg_word);
		diagnostic_hold <= 1'b1;
		device_reset <= 1'b0;
		repeat (1500) @(posedge core_clk);
		chk("hold_done", 36'h0, {35'h0, config_done});
		chk("hold_reads", 36'h0, 36'(n_reads));
		$display("test done: hold");
		device_reset <= 1'b1;
		diagnostic_hold <= 1'b0;
		wb_read(8'h10, 32'h0000_0000);
		wb_cycle(1'b1, ADDR_CTRL, 32'h0000_0001);
		external_bus_request <= 1'b1;
		run_cfg(1'b0, 5'd0, 36'h0, pack(12'h000, 5'h1E, 5'h01, 5'h03, 5'h05, 1'b1, 1'b1), 8, 1'b0);
		run_cfg(1'b0, 5'd8, 36'h0, pack(12'h000, 5'h1E, 5'h01, 5'h02, 5'h03, 1'b0, 1'b0), 0, 1'b0);
		run_cfg(1'b0, 5'd11, 36'h0, pack(12'hAAA, 5'h1E, 5'h02, 5'h04, 5'h0D, 1'b1, 1'b1), 8, 1'b0);
		run_cfg(1'b0, 5'd31, 36'h0, CFG_DEFAULT, 8, 1'b0);
		w = {$urandom, $urandom};
		w[34] = 1'b1;
		run_cfg(1'b1, 5'd0, w, w, 8, 1'b1);
		w = {$urandom, $urandom};
		w[34] = 1'b0;
		run_cfg(1'b1, 5'd0, w, w, 0, 1'b0);
		chk("grant_on", 36'h1, {35'h0, bus_request_granted});
		wb_cycle(1'b1, ADDR_CTRL, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		chk("grant_off", 36'h0, {35'h0, bus_request_granted});
		wb_cycle(1'b1, ADDR_CFG_LO, 32'h0000_0000);
		wb_read(ADDR_CFG_LO, w[31:0]);
		stop_test();
	end

	// watchdog sized well past six start-ups and the hold test
	initial begin
		repeat (40000) @(posedge core_clk);
		fail_count++;
		$display("BAD watchdog expected finish seen hang");
		stop_test();
	end
endmodule // memory_interface_config_loader_bench
